// ---- hdl/pack_status_words.sv ----
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
// Notes on behaviour
// - Read right after writing control word returns 0xFFA5, once only.
// - Later control word reads return live control status bits.
// - Write to control word acts like a subcommand register write.
// - Control bit 2 shows deep sleep; bits 15 to 3 reserved.
// - Control bit 1 shows load detect timed out and stopped.
// - Control bit 0 shows pullup state at last load detect measurement.
// - Pack bit 15 shows sleep mode; bit 14 reserved.
// - Pack bit 13 shows shutdown pending, by command or pin held over 1 s.
// - Pack bit 12 shows at least one permanent fault triggered.
// - Pack bit 11 shows an enabled safety fault triggered.
// - Pack bit 10 holds fuse pin sample, refreshed each second in normal mode.
// - Pack bits 9:8 encode security level 0 to 3.
// - Locked level blocks configuration reads and writes and some commands.
// - Unlocked level allows reads; writes only in configuration edit mode.
// - Full access level allows every command and configuration access.
// - Pack bit 7 shows NVM writes blocked; forced high when nothing pending.
// - On edit mode entry, blocked flag is evaluated once and then held.
// - Pack bit 6 shows NVM data pending until conditions allow writing.
// - NVM programming from edit mode never sets the pending flag.
// - Pack bit 5 set only during open-wire check, never when disabled.
// - Edit mode active only after subcommand 0x0090 fully processed.
module pack_status_words #(
    parameter longint unsigned SHUT_HOLD_CYCLES   = status_pkg::SHUT_HOLD_CYCLES,
    parameter longint unsigned FUSE_PERIOD_CYCLES = status_pkg::FUSE_PERIOD_CYCLES
) (
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [status_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [31:0]                     pwdata,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire status_pkg::hw_status_t          hw_status,
    input  wire logic                            fuse_pin,
    input  wire logic                            shutdown_pin,
    output status_pkg::access_t                  access,
    output logic                                 config_edit_active,
    output logic                                 shutdown_pending,
    output logic                                 subcmd_valid,
    output logic      [15:0]                     subcmd_code
);

    localparam logic [status_pkg::CNT_W-1:0] SHUT_LAST =
        status_pkg::CNT_W'(SHUT_HOLD_CYCLES);
    localparam logic [status_pkg::CNT_W-1:0] FUSE_LAST =
        status_pkg::CNT_W'(FUSE_PERIOD_CYCLES - 64'd1);

    typedef struct packed {
        logic                            marker_armed;
        status_pkg::edit_state_t         edit;
        logic                            shut_pend;
        logic                            fuse;
        logic                            blocked_hold;
        logic                            wr_pend;
        logic [status_pkg::CNT_W-1:0]    shut_cnt;
        logic [status_pkg::CNT_W-1:0]    sec_cnt;
        logic [31:0]                     rdata;
        logic                            err;
        logic [15:0]                     sub_code;
        logic                            sub_valid;
    } core_state_t;

    core_state_t s;
    core_state_t next_s;

    logic [1:0] pins_sync;
    logic       fuse_sync;
    logic       shut_sync;

    // Fuse and shutdown pins come from outside the clock domain
    pin_sync #(
        .WIDTH (2)
    ) u_pin_sync (
        .pclk         (pclk),
        .presetn      (presetn),
        .pin_async    ({fuse_pin, shutdown_pin}),
        .pin_sync_out (pins_sync)
    );

    assign fuse_sync = pins_sync[1];
    assign shut_sync = pins_sync[0];

    // Register decode, shared by setup and access phases
    function automatic logic [7:0] reg_index(input logic [status_pkg::ADDR_W-1:0] a);
        reg_index = a[status_pkg::IDX_LSB +: 8];
    endfunction

    function automatic logic is_mapped(input logic [status_pkg::ADDR_W-1:0] a);
        logic [7:0] i;
        i = reg_index(a);
        is_mapped = (a[status_pkg::IDX_LSB-1:0] == 2'h0)
                  && (i == status_pkg::IDX_CTRL || i == status_pkg::IDX_PACK
                   || i == status_pkg::IDX_SUBCMD || i == status_pkg::IDX_MODE);
    endfunction

    // Subcommands gated by security level
    function automatic logic cmd_allowed(input status_pkg::sec_level_t lvl);
        cmd_allowed = (lvl == status_pkg::SEC_FULL)
                   || (lvl == status_pkg::SEC_UNLOCKED);
    endfunction

    logic        edit_on;
    logic        normal_mode;
    logic [15:0] ctrl_word;
    logic [15:0] pack_word;
    logic        blocked_now;

    assign edit_on     = (s.edit == status_pkg::EDIT_ON);
    assign normal_mode = !hw_status.sleep_mode && !hw_status.deep_sleep_flag;

    // Live control word; all other bits stay zero
    always_comb begin
        ctrl_word = 16'h0000;
        ctrl_word[status_pkg::CTRL_DEEP]   = hw_status.deep_sleep_flag;
        ctrl_word[status_pkg::CTRL_LD_EXP] = hw_status.load_detect_expired;
        ctrl_word[status_pkg::CTRL_PULLUP] = hw_status.load_detect_pullup_on;
    end

    // Blocked flag: held in edit mode, forced high with nothing pending
    always_comb begin
        if (edit_on) begin
            blocked_now = s.blocked_hold;
        end else if (!s.wr_pend) begin
            blocked_now = 1'b1;
        end else begin
            blocked_now = !hw_status.nvm_cond_ok;
        end
    end

    // Live pack word; bit 14 and bits 4:0 stay zero
    always_comb begin
        pack_word = 16'h0000;
        pack_word[status_pkg::PACK_SLEEP]   = hw_status.sleep_mode;
        pack_word[status_pkg::PACK_SHUT]    = s.shut_pend;
        pack_word[status_pkg::PACK_PERM]    = hw_status.permanent_fault_flag;
        pack_word[status_pkg::PACK_SAFETY]  = hw_status.safety_fault;
        pack_word[status_pkg::PACK_FUSE]    = s.fuse;
        pack_word[status_pkg::PACK_SEC_LSB +: 2] = hw_status.security_level;
        pack_word[status_pkg::PACK_NVM_BLK] = blocked_now;
        pack_word[status_pkg::PACK_NVM_PND] = s.wr_pend;
        pack_word[status_pkg::PACK_OPENW]   =
            hw_status.open_wire_check_active && hw_status.open_wire_enabled;
    end

    logic       setup;
    logic       done;
    logic       wr_done;
    logic [7:0] idx;
    logic       sub_write;
    logic [15:0] sub_data;

    assign setup   = psel && !penable;
    assign done    = psel && penable;
    assign wr_done = done && pwrite && is_mapped(paddr);
    assign idx     = reg_index(paddr);
    assign sub_data = pwdata[15:0];
    // Legacy control word write behaves as a subcommand write
    assign sub_write = wr_done
        && (idx == status_pkg::IDX_SUBCMD || idx == status_pkg::IDX_CTRL);

    // Next-state logic for the whole block
    always_comb begin
        next_s           = s;
        next_s.sub_valid = 1'b0;

        // Read data captured in setup so the access phase sees flops
        if (setup) begin
            next_s.err   = !is_mapped(paddr);
            next_s.rdata = 32'h0000_0000;
            if (!pwrite && is_mapped(paddr)) begin
                case (idx)
                    status_pkg::IDX_CTRL: begin
                        if (s.marker_armed) begin
                            next_s.rdata[15:0] = status_pkg::CTRL_MARKER;
                        end else begin
                            next_s.rdata[15:0] = ctrl_word;
                        end
                    end
                    status_pkg::IDX_PACK: begin
                        next_s.rdata[15:0] = pack_word;
                    end
                    status_pkg::IDX_SUBCMD: begin
                        next_s.rdata[15:0] = s.sub_code;
                    end
                    status_pkg::IDX_MODE: begin
                        next_s.rdata[status_pkg::MODE_EDIT] = edit_on;
                    end
                    default: begin
                        next_s.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end

        // Marker armed by a control write, spent by the next access
        if (done) begin
            next_s.marker_armed = wr_done && (idx == status_pkg::IDX_CTRL);
        end

        // Subcommand issue; pack word writes fall through ignored
        if (sub_write) begin
            next_s.sub_code  = sub_data;
            next_s.sub_valid = 1'b1;
        end

        // Edit mode sequencing, one cycle to process the request
        case (s.edit)
            status_pkg::EDIT_OFF: begin
                if (s.sub_valid && s.sub_code == status_pkg::SUB_ENTER_EDIT
                    && cmd_allowed(hw_status.security_level)) begin
                    next_s.edit = status_pkg::EDIT_ENTER;
                end
            end
            status_pkg::EDIT_ENTER: begin
                // Conditions sampled once on entry, then frozen
                next_s.blocked_hold = !hw_status.nvm_cond_ok;
                next_s.edit         = status_pkg::EDIT_ON;
            end
            status_pkg::EDIT_ON: begin
                if (s.sub_valid && s.sub_code == status_pkg::SUB_EXIT_EDIT) begin
                    next_s.edit = status_pkg::EDIT_OFF;
                end
            end
            default: begin
                next_s.edit = status_pkg::EDIT_OFF;
            end
        endcase

        // Pending NVM data: request outside edit mode sets, set wins
        if (!edit_on && s.edit != status_pkg::EDIT_ENTER) begin
            if (hw_status.nvm_write_request) begin
                next_s.wr_pend = 1'b1;
            end else if (hw_status.nvm_cond_ok) begin
                next_s.wr_pend = 1'b0;
            end
        end

        // Shutdown pin must stay asserted beyond the hold time
        if (!shut_sync) begin
            next_s.shut_cnt = '0;
        end else if (s.shut_cnt != SHUT_LAST) begin
            next_s.shut_cnt = s.shut_cnt + 1'b1;
        end
        if ((shut_sync && s.shut_cnt == SHUT_LAST)
            || (s.sub_valid && s.sub_code == status_pkg::SUB_SHUTDOWN
                && cmd_allowed(hw_status.security_level))) begin
            next_s.shut_pend = 1'b1;
        end

        // One-second tick samples the fuse pin in normal mode
        if (s.sec_cnt == FUSE_LAST) begin
            next_s.sec_cnt = '0;
            if (normal_mode) begin
                next_s.fuse = fuse_sync;
            end
        end else begin
            next_s.sec_cnt = s.sec_cnt + 1'b1;
        end
    end

    // Single state register; reset brings every flag to idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s      <= '0;
            s.edit <= status_pkg::EDIT_OFF;
        end else begin
            s <= next_s;
        end
    end

    // Zero wait states; read data already latched in setup
    assign pready  = 1'b1;
    assign pslverr = psel && penable && s.err;
    assign prdata  = s.rdata;

    // Configuration access permissions by security level
    always_comb begin
        access = '0;
        case (hw_status.security_level)
            status_pkg::SEC_FULL: begin
                access.cfg_read_allow       = 1'b1;
                access.cfg_write_allow      = 1'b1;
                access.restricted_cmd_allow = 1'b1;
            end
            status_pkg::SEC_UNLOCKED: begin
                access.cfg_read_allow       = 1'b1;
                access.cfg_write_allow      = edit_on;
                access.restricted_cmd_allow = 1'b1;
            end
            status_pkg::SEC_LOCKED: begin
                access = '0;
            end
            default: begin
                // Not yet initialised: nothing allowed
                access = '0;
            end
        endcase
    end

    assign config_edit_active = edit_on;
    assign shutdown_pending   = s.shut_pend;
    assign subcmd_valid       = s.sub_valid;
    assign subcmd_code        = s.sub_code;

endmodule // pack_status_words

// ---- hdl/pin_sync.sv ----
`timescale 1ns/100ps
// Two-stage synchroniser for asynchronous pins
module pin_sync #(
    parameter int unsigned WIDTH = 2
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] pin_async,
    output logic      [WIDTH-1:0] pin_sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t s;
    sync_state_t next_s;

    // First stage feeds only the second stage
    always_comb begin
        next_s        = s;
        next_s.stage1 = pin_async;
        next_s.stage2 = s.stage1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pin_sync_out = s.stage2;

endmodule // pin_sync

// ---- hdl/status_pkg.sv ----
package status_pkg;

    // Clock and time figures
    localparam int unsigned CLK_HZ        = 25000000;
    localparam int unsigned SHUT_HOLD_MS  = 1000;
    localparam int unsigned FUSE_PERIOD_MS = 1000;
    localparam int unsigned MS_PER_S      = 1000;
    localparam longint unsigned SHUT_HOLD_CYCLES =
        64'(SHUT_HOLD_MS) * 64'(CLK_HZ) / 64'(MS_PER_S);
    localparam longint unsigned FUSE_PERIOD_CYCLES =
        64'(FUSE_PERIOD_MS) * 64'(CLK_HZ) / 64'(MS_PER_S);
    localparam int unsigned CNT_W = 25;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL   = 8'h00;
    localparam logic [7:0] IDX_PACK   = 8'h12;
    localparam logic [7:0] IDX_SUBCMD = 8'h3E;
    localparam logic [7:0] IDX_MODE   = 8'h40;
    localparam int unsigned ADDR_W    = 12;
    localparam int unsigned IDX_LSB   = 2;

    // Control status word fields
    localparam int unsigned CTRL_PULLUP  = 0;
    localparam int unsigned CTRL_LD_EXP  = 1;
    localparam int unsigned CTRL_DEEP    = 2;
    localparam logic [15:0] CTRL_MARKER  = 16'hFFA5;

    // Pack status word fields
    localparam int unsigned PACK_OPENW   = 5;
    localparam int unsigned PACK_NVM_PND = 6;
    localparam int unsigned PACK_NVM_BLK = 7;
    localparam int unsigned PACK_SEC_LSB = 8;
    localparam int unsigned PACK_FUSE    = 10;
    localparam int unsigned PACK_SAFETY  = 11;
    localparam int unsigned PACK_PERM    = 12;
    localparam int unsigned PACK_SHUT    = 13;
    localparam int unsigned PACK_SLEEP   = 15;

    // Mode register field
    localparam int unsigned MODE_EDIT    = 0;

    // Subcommand codes
    localparam logic [15:0] SUB_ENTER_EDIT = 16'h0090;
    localparam logic [15:0] SUB_EXIT_EDIT  = 16'h0092;
    localparam logic [15:0] SUB_SHUTDOWN   = 16'h0010;

    // Security levels
    typedef enum logic [1:0] {
        SEC_UNINIT   = 2'h0,
        SEC_FULL     = 2'h1,
        SEC_UNLOCKED = 2'h2,
        SEC_LOCKED   = 2'h3
    } sec_level_t;

    // Configuration edit mode sequencing
    typedef enum logic [2:0] {
        EDIT_OFF   = 3'h1,
        EDIT_ENTER = 3'h2,
        EDIT_ON    = 3'h4
    } edit_state_t;

    // Status inputs from the on-chip condition generators
    typedef struct packed {
        logic       deep_sleep_flag;
        logic       load_detect_expired;
        logic       load_detect_pullup_on;
        logic       sleep_mode;
        logic       permanent_fault_flag;
        logic       safety_fault;
        sec_level_t security_level;
        logic       nvm_cond_ok;
        logic       nvm_write_request;
        logic       open_wire_check_active;
        logic       open_wire_enabled;
    } hw_status_t;

    // Access permissions handed to the configuration store
    typedef struct packed {
        logic cfg_read_allow;
        logic cfg_write_allow;
        logic restricted_cmd_allow;
    } access_t;

endpackage

// ---- verif/apb_host.sv ----
`timescale 1ns/100ps
module apb_host (
    input  wire logic                          pclk,
    output logic                               psel,
    output logic                               penable,
    output logic                               pwrite,
    output logic [status_pkg::ADDR_W-1:0]      paddr,
    output logic [31:0]                        pwdata,
    input  wire logic [31:0]                   prdata,
    input  wire logic                          pready
);
    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
    end
    // One transfer, entered after a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        penable <= 1'b0;
    endtask
    // Release select
    task automatic idle();
        psel <= 1'b0;
        @(posedge pclk);
    endtask
endmodule // apb_host

// ---- verif/status_props.sv ----
`timescale 1ns/100ps
module status_props #(
    parameter longint unsigned SHUT_HOLD_CYCLES = status_pkg::SHUT_HOLD_CYCLES
) (
    input wire logic                          pclk,
    input wire logic                          presetn,
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pwrite,
    input wire logic [status_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                   pwdata,
    input wire logic [31:0]                   prdata,
    input wire logic                          pready,
    input wire logic                          pslverr,
    input wire status_pkg::hw_status_t        hw_status,
    input wire logic                          fuse_pin,
    input wire logic                          shutdown_pin,
    input wire status_pkg::access_t           access,
    input wire logic                          config_edit_active,
    input wire logic                          shutdown_pending,
    input wire logic                          subcmd_valid,
    input wire logic [15:0]                   subcmd_code
);
    logic [31:0] hold_cnt;
    logic        wr_ctrl;
    logic        rd_set;
    logic        may_cmd;
    // Raw pin high time; slack below covers the synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hold_cnt <= 32'h0;
        else hold_cnt <= shutdown_pin ? hold_cnt + 32'h1 : 32'h0;
    end
    // Bus phase decodes
    assign wr_ctrl = psel && penable && pwrite && paddr == 12'h000;
    assign rd_set  = psel && !penable && !pwrite;
    assign may_cmd = hw_status.security_level inside {status_pkg::SEC_FULL,
                                                      status_pkg::SEC_UNLOCKED};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    ctrl_alias_a: assert property (wr_ctrl |=> subcmd_valid && subcmd_code == $past(pwdata[15:0]))
        else $error("control write issued no subcommand");
    marker_once_a: assert property (wr_ctrl ##1 (rd_set && paddr == 12'h000) |=> prdata == 32'h0000FFA5)
        else $error("marker missing after control write");
    live_ctrl_a: assert property (rd_set && paddr == 12'h000 && $past(psel && penable && !pwrite && paddr == 12'h000) |=> prdata == {29'h0, $past(hw_status.deep_sleep_flag), $past(hw_status.load_detect_expired), $past(hw_status.load_detect_pullup_on)})
        else $error("control word not live");
    pack_word_a: assert property (rd_set && paddr == 12'h048 |=> prdata[31:11] == {16'h0, $past(hw_status.sleep_mode), 1'b0, $past(shutdown_pending), $past(hw_status.permanent_fault_flag), $past(hw_status.safety_fault)} && prdata[9:8] == $past(hw_status.security_level) && prdata[5:0] == {$past(hw_status.open_wire_check_active && hw_status.open_wire_enabled), 5'h0})
        else $error("pack word field wrong");
    nvm_force_a: assert property (rd_set && paddr == 12'h048 && !config_edit_active |=> prdata[6] || prdata[7])
        else $error("blocked flag not forced");
    shut_cmd_a: assert property (subcmd_valid && subcmd_code == 16'h0010 && may_cmd |=> shutdown_pending)
        else $error("shutdown command not pending");
    shut_pin_a: assert property (hold_cnt == 32'(SHUT_HOLD_CYCLES) + 32'h5 |-> shutdown_pending)
        else $error("long pin hold not pending");
    edit_entry_a: assert property (subcmd_valid && subcmd_code == 16'h0090 && !config_edit_active && may_cmd |=> !config_edit_active ##1 config_edit_active)
        else $error("edit mode entry timing wrong");
    edit_refuse_a: assert property (subcmd_valid && subcmd_code == 16'h0090 && hw_status.security_level == status_pkg::SEC_LOCKED && !config_edit_active |=> !config_edit_active [*2])
        else $error("locked level entered edit mode");
    access_lock_a: assert property (hw_status.security_level == status_pkg::SEC_LOCKED |-> !access.cfg_read_allow && !access.cfg_write_allow)
        else $error("locked level allows config");
    access_open_a: assert property (hw_status.security_level == status_pkg::SEC_FULL |-> access == 3'h7)
        else $error("full level restricted");
    unmapped_err_a: assert property (psel && penable && paddr == 12'h004 |-> pslverr && pready)
        else $error("unmapped access not refused");
endmodule // status_props

bind pack_status_words status_props #(.SHUT_HOLD_CYCLES(SHUT_HOLD_CYCLES)) u_status_props (.*);

// ---- verif/tb_pack_status_words.sv ----
`timescale 1ns/100ps
module tb_pack_status_words;
    localparam int SHUT_N = 20;
    localparam int FUSE_N = 16;
    logic                   pclk = 1'b0;
    logic                   presetn, psel, penable, pwrite, pready, pslverr;
    logic                   fuse_pin, shutdown_pin, config_edit_active;
    logic                   shutdown_pending, subcmd_valid;
    logic [11:0]            paddr;
    logic [31:0]            pwdata, prdata;
    logic [15:0]            subcmd_code;
    status_pkg::hw_status_t hw;
    status_pkg::access_t    access;
    int                     n_errors = 0;
    int                     num_checks = 0;

    // 25 MHz clock
    always #20 pclk = ~pclk;

    pack_status_words #(.SHUT_HOLD_CYCLES(SHUT_N), .FUSE_PERIOD_CYCLES(FUSE_N))
    u_pack_status_words (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .hw_status(hw), .fuse_pin, .shutdown_pin, .access,
        .config_edit_active, .shutdown_pending, .subcmd_valid, .subcmd_code);

    apb_host u_apb_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Control write, two reads
    task automatic t_marker();
        logic [31:0] q;
        u_apb_host.xfer(1'b1, 12'h000, 32'h00001234, q);
        u_apb_host.xfer(1'b0, 12'h000, 32'h0, q);
        chk(q, 32'h0000FFA5);
        chk({16'h0, subcmd_code}, 32'h00001234);
        u_apb_host.xfer(1'b0, 12'h000, 32'h0, q);
        chk(q, 32'h0);
        u_apb_host.idle();
    endtask

    // All live control bit combinations
    task automatic t_ctrl();
        logic [31:0] q;
        for (int i = 0; i < 8; i++) begin
            {hw.deep_sleep_flag, hw.load_detect_expired, hw.load_detect_pullup_on} <= 3'(i);
            u_apb_host.xfer(1'b0, 12'h000, 32'h0, q);
            chk(q, 32'(i));
        end
        u_apb_host.idle();
    endtask

    // Each security level, mixed flags
    task automatic t_pack();
        logic [31:0] q;
        logic [1:0]  s;
        for (int i = 0; i < 4; i++) begin
            s = 2'(i);
            hw.sleep_mode <= s[0];
            hw.permanent_fault_flag <= s[1];
            hw.safety_fault <= ~s[0];
            hw.security_level <= status_pkg::sec_level_t'(s);
            hw.open_wire_check_active <= 1'b1;
            hw.open_wire_enabled <= s[1];
            u_apb_host.xfer(1'b0, 12'h048, 32'h0, q);
            chk(q, {16'h0, s[0], 2'h0, s[1], ~s[0], 1'b0, s, 2'h2, s[1], 5'h0});
            if (s == 2'h1) chk(32'(access), 32'h7);
            if (s == 2'h3) chk(32'(access[2:1]), 32'h0);
        end
        u_apb_host.idle();
    endtask

    // Edit mode from unlocked; blocked held
    task automatic t_edit();
        logic [31:0] q;
        hw <= '0;
        hw.security_level <= status_pkg::SEC_UNLOCKED;
        u_apb_host.xfer(1'b1, 12'h0F8, 32'h00000090, q);
        u_apb_host.idle();
        repeat (3) @(posedge pclk);
        chk(32'(config_edit_active), 32'h1);
        chk(32'(access[2:1]), 32'h3);
        hw.nvm_cond_ok <= 1'b1;
        hw.nvm_write_request <= 1'b1;
        u_apb_host.xfer(1'b0, 12'h100, 32'h0, q);
        chk(q, 32'h1);
        u_apb_host.xfer(1'b0, 12'h048, 32'h0, q);
        chk(q & 32'h000000C0, 32'h00000080);
        hw.nvm_write_request <= 1'b0;
        u_apb_host.xfer(1'b1, 12'h0F8, 32'h00000092, q);
        u_apb_host.idle();
        repeat (2) @(posedge pclk);
        chk(32'(access[2:1]), 32'h2);
    endtask

    // Pending write, then release
    task automatic t_nvm();
        logic [31:0] q;
        hw.nvm_cond_ok <= 1'b0;
        hw.nvm_write_request <= 1'b1;
        @(posedge pclk);
        hw.nvm_write_request <= 1'b0;
        u_apb_host.xfer(1'b0, 12'h048, 32'h0, q);
        chk(q & 32'h000000C0, 32'h000000C0);
        hw.nvm_cond_ok <= 1'b1;
        u_apb_host.idle();
        u_apb_host.xfer(1'b0, 12'h048, 32'h0, q);
        chk(q & 32'h000000C0, 32'h00000080);
        u_apb_host.idle();
    endtask

    // Locked level refusals; unmapped read
    task automatic t_lock();
        logic [31:0] q;
        hw.security_level <= status_pkg::SEC_LOCKED;
        u_apb_host.xfer(1'b1, 12'h0F8, 32'h00000090, q);
        u_apb_host.xfer(1'b1, 12'h0F8, 32'h00000010, q);
        u_apb_host.xfer(1'b0, 12'h004, 32'h0, q);
        chk(q, 32'h0);
        u_apb_host.idle();
        repeat (3) @(posedge pclk);
        chk({30'h0, config_edit_active, shutdown_pending}, 32'h0);
    endtask

    // Pin holds, fuse, reset, command
    task automatic t_shut();
        logic [31:0] q;
        fuse_pin <= 1'b1;
        shutdown_pin <= 1'b1;
        repeat (10) @(posedge pclk);
        shutdown_pin <= 1'b0;
        @(posedge pclk);
        chk(32'(shutdown_pending), 32'h0);
        shutdown_pin <= 1'b1;
        repeat (SHUT_N + 8) @(posedge pclk);
        chk(32'(shutdown_pending), 32'h1);
        u_apb_host.xfer(1'b0, 12'h048, 32'h0, q);
        chk(q & 32'h00002400, 32'h00002400);
        u_apb_host.idle();
        shutdown_pin <= 1'b0;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        hw.security_level <= status_pkg::SEC_FULL;
        @(posedge pclk);
        u_apb_host.xfer(1'b1, 12'h0F8, 32'h00000010, q);
        u_apb_host.idle();
        @(posedge pclk);
        chk(32'(shutdown_pending), 32'h1);
    endtask

    // Main sequence
    initial begin
        presetn = 1'b0;
        hw = '0;
        fuse_pin = 1'b0;
        shutdown_pin = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_marker();
        t_ctrl();
        t_pack();
        t_edit();
        t_nvm();
        t_lock();
        t_shut();
        end_of_test();
    end

    // Watchdog, over twenty times the run
    initial begin
        repeat (3000) @(posedge pclk);
        n_errors++;
        end_of_test();
    end
endmodule // tb_pack_status_words
